// ==== core/edpr_hamming.sv ====
// Hamming SEC-DED encoder and decoder
module edpr_hamming #(
    parameter int DATA_W = 32,
    parameter int CHK_W = edpr_pkg::edpr_check_bits(32)
) (
    enc_data,
    enc_code,
    dec_code,
    dec_data,
    dec_single,
    dec_double
);
    localparam int CODE_W = DATA_W + CHK_W + 1;
    input wire logic [DATA_W-1:0] enc_data;
    output logic [CODE_W-1:0] enc_code;
    input wire logic [CODE_W-1:0] dec_code;
    output logic [DATA_W-1:0] dec_data;
    output logic dec_single;
    output logic dec_double;

    // Encode: data at non power-of-two positions, parity at powers, overall at 0
    always_comb begin
        logic [CODE_W-1:0] cw;
        int d;
        cw = '0;
        d = 0;
        for (int i = 1; i < CODE_W; i++) begin
            if ((i & (i - 1)) != 0) begin
                cw[i] = enc_data[d];
                d = d + 1;
            end
        end
        for (int p = 0; p < CHK_W; p++) begin
            for (int i = 1; i < CODE_W; i++) begin
                if (((i >> p) & 1) == 1 && (i != (1 << p))) begin
                    cw[1 << p] = cw[1 << p] ^ cw[i];
                end
            end
        end
        cw[0] = ^cw[CODE_W-1:1];
        enc_code = cw;
    end

    // Decode: syndrome flips one bit, overall parity tells single from double
    always_comb begin
        logic [CODE_W-1:0] fixed;
        logic [CHK_W-1:0] syn;
        logic par;
        int d;
        fixed = dec_code;
        syn = '0;
        d = 0;
        for (int i = 1; i < CODE_W; i++) begin
            if (dec_code[i]) begin
                syn = syn ^ CHK_W'(i);
            end
        end
        par = ^dec_code;
        dec_single = par; // Odd parity: single error, correctable
        dec_double = !par && (syn != '0); // Even parity, nonzero syndrome
        if (par && (int'(syn) < CODE_W)) begin
            fixed[syn] = ~dec_code[syn];
        end
        dec_data = '0;
        for (int i = 1; i < CODE_W; i++) begin
            if ((i & (i - 1)) != 0) begin
                dec_data[d] = fixed[i];
                d = d + 1;
            end
        end
    end
endmodule

// ==== core/edpr_pkg.sv ====
// Shared constants and types for the ECC dual-port memory block
package edpr_pkg;
    // Port collision behaviour during a write
    typedef enum logic [1:0] {
        EDPR_READ_FIRST,
        EDPR_WRITE_FIRST,
        EDPR_NO_CHANGE
    } edpr_mode_type;

    // Memory organisation
    typedef enum logic [1:0] {
        EDPR_SIMPLE_DUAL,
        EDPR_TRUE_DUAL,
        EDPR_SINGLE_PORT
    } edpr_mem_type;

    // Error correction variant
    typedef enum logic [1:0] {
        EDPR_NO_ECC,
        EDPR_HARD_ECC,
        EDPR_SOFT_ECC
    } edpr_ecc_type;

    localparam int EDPR_SOFT_MAX_WIDTH = 64;
    localparam int EDPR_BYTE_PLAIN = 8;
    localparam int EDPR_BYTE_PARITY = 9;
    localparam int EDPR_DEF_WIDTH = 32;
    localparam int EDPR_DEF_DEPTH = 256;
    localparam int EDPR_BANK_DEPTH = 64;

    // Number of Hamming check bits for a data width
    function automatic int edpr_check_bits(input int width);
        int p;
        p = 1;
        while ((1 << p) < width + p + 1) begin
            p = p + 1;
        end
        return p;
    endfunction
endpackage

// ==== core/edpr_ram.sv ====
// ECC-capable dual-port block memory, common-clock build
//
// How it works
// [RULE_01] ECC only allowed with simple dual-port organisation.
// [RULE_02] Soft ECC: data at most 64 bits, Hamming protected.
// [RULE_03] Single-bit error in stored word is corrected on read.
// [RULE_04] Double-bit error is flagged, not corrected.
// [RULE_05] Injection inputs corrupt the stored word during a write.
// [RULE_06] Hard ECC: no byte-write enables, full word written.
// [RULE_07] Hard ECC: all port widths equal.
// [RULE_08] Hard ECC: no output reset inputs or reset value.
// [RULE_09] Hard ECC: no memory preload.
// [RULE_10] Soft ECC: optional input and output register stages.
// [RULE_11] Common clock only when both port clocks share one source.
// [RULE_12] Common clock: simple dual read-first, others write-first.
// [RULE_13] Byte enables cover 8 or 9 bits; width multiple of byte.
// [RULE_14] Low power: enable only the bank being accessed.
// [RULE_15] Per-port collision mode: read-first, write-first, no-change; only MODE_B is applied, MODE_A is unused.
// [RULE_16] Port enable either tied on or gated by enable input.
// [RULE_17] Read depth derived from write width, depth and read width.
// [RULE_18] During write, output old, new or unchanged word by mode.
// [RULE_19] Error flags accompany read data, aligned.
module edpr_ram #(
    parameter edpr_pkg::edpr_ecc_type ECC = edpr_pkg::EDPR_SOFT_ECC,
    parameter edpr_pkg::edpr_mem_type MEM = edpr_pkg::EDPR_SIMPLE_DUAL,
    parameter int WRITE_W = edpr_pkg::EDPR_DEF_WIDTH,
    parameter int READ_W = edpr_pkg::EDPR_DEF_WIDTH,
    parameter int WRITE_DEPTH = edpr_pkg::EDPR_DEF_DEPTH,
    parameter int BYTE_W = edpr_pkg::EDPR_BYTE_PLAIN,
    parameter bit USE_BYTE_WE = 1'b0,
    parameter bit USE_ENABLE_A = 1'b1,
    parameter bit USE_ENABLE_B = 1'b1,
    parameter bit USE_OUT_RESET = 1'b0,
    parameter bit USE_INIT = 1'b0,
    parameter bit IN_REG = 1'b0,
    parameter bit OUT_REG = 1'b0,
    parameter bit LOW_POWER = 1'b1,
    parameter bit COMMON_CLOCK = 1'b1,
    parameter edpr_pkg::edpr_mode_type MODE_A = edpr_pkg::EDPR_READ_FIRST,
    parameter edpr_pkg::edpr_mode_type MODE_B = edpr_pkg::EDPR_READ_FIRST,
    parameter int ADDR_W = $clog2(WRITE_DEPTH),
    parameter int BYTES = (WRITE_W + BYTE_W - 1) / BYTE_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic port_a_enable,
    input wire logic [BYTES-1:0] port_a_write_enable,
    input wire logic [ADDR_W-1:0] port_a_addr,
    input wire logic [WRITE_W-1:0] port_a_write_data,
    input wire logic inject_single_bit_error,
    input wire logic inject_double_bit_error,
    input wire logic port_b_enable,
    input wire logic [ADDR_W-1:0] port_b_addr,
    output logic [READ_W-1:0] port_b_read_data,
    output logic port_b_read_valid,
    output logic single_bit_error,
    output logic double_bit_error
);
    localparam int CHK_W = edpr_pkg::edpr_check_bits(WRITE_W);
    localparam int CODE_W = WRITE_W + CHK_W + 1;
    localparam bit ECC_ON = (ECC != edpr_pkg::EDPR_NO_ECC);
    localparam int READ_DEPTH = (WRITE_DEPTH * WRITE_W) / READ_W; // [RULE_17]
    localparam int BANK_D = edpr_pkg::EDPR_BANK_DEPTH;
    localparam int BANKS = (WRITE_DEPTH + BANK_D - 1) / BANK_D;
    localparam int BANK_AW = (BANKS > 1) ? $clog2(BANKS) : 1;
    localparam int LOW_AW = $clog2(BANK_D);

    // Elaboration checks of the configuration
    initial begin
        if (ECC_ON && MEM != edpr_pkg::EDPR_SIMPLE_DUAL)
            $error("ECC needs simple dual-port"); // [RULE_01]
        if (ECC == edpr_pkg::EDPR_SOFT_ECC && WRITE_W > edpr_pkg::EDPR_SOFT_MAX_WIDTH)
            $error("Soft ECC width too large"); // [RULE_02]
        if (ECC == edpr_pkg::EDPR_HARD_ECC && USE_BYTE_WE)
            $error("Byte writes not with hard ECC"); // [RULE_06]
        if ((ECC_ON || USE_BYTE_WE) && READ_W != WRITE_W)
            $error("Port widths must match"); // [RULE_07]
        if (ECC == edpr_pkg::EDPR_HARD_ECC && (USE_OUT_RESET || USE_INIT))
            $error("No reset value or preload with hard ECC"); // [RULE_08] [RULE_09]
        if (USE_BYTE_WE && BYTE_W != edpr_pkg::EDPR_BYTE_PLAIN
                && BYTE_W != edpr_pkg::EDPR_BYTE_PARITY)
            $error("Byte size must be 8 or 9"); // [RULE_13]
        if (USE_BYTE_WE && (WRITE_W % BYTE_W) != 0)
            $error("Width not a byte multiple"); // [RULE_13]
        if (COMMON_CLOCK && MEM == edpr_pkg::EDPR_SIMPLE_DUAL
                && MODE_B != edpr_pkg::EDPR_READ_FIRST)
            $error("Common clock simple dual must read first"); // [RULE_12]
        if (COMMON_CLOCK && MEM != edpr_pkg::EDPR_SIMPLE_DUAL
                && MODE_B != edpr_pkg::EDPR_WRITE_FIRST)
            $error("Common clock needs write first"); // [RULE_12]
        if (!COMMON_CLOCK)
            $error("Only the common-clock build exists"); // [RULE_11]
        if (READ_DEPTH != WRITE_DEPTH || WRITE_DEPTH < 2)
            $error("Unsupported depth ratio");
    end

    // Optional input stage
    logic en_a_ff, en_b_ff, inj_s_ff, inj_d_ff;
    logic [BYTES-1:0] we_a_ff;
    logic [ADDR_W-1:0] addr_a_ff, addr_b_ff;
    logic [WRITE_W-1:0] din_a_ff;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            en_a_ff <= 1'b0;
            en_b_ff <= 1'b0;
            we_a_ff <= '0;
            inj_s_ff <= 1'b0;
            inj_d_ff <= 1'b0;
            addr_a_ff <= '0;
            addr_b_ff <= '0;
            din_a_ff <= '0;
        end else begin
            en_a_ff <= port_a_enable;
            en_b_ff <= port_b_enable;
            we_a_ff <= port_a_write_enable;
            inj_s_ff <= inject_single_bit_error;
            inj_d_ff <= inject_double_bit_error;
            addr_a_ff <= port_a_addr;
            addr_b_ff <= port_b_addr;
            din_a_ff <= port_a_write_data;
        end
    end

    // Select registered or direct inputs
    wire use_in = IN_REG && ECC == edpr_pkg::EDPR_SOFT_ECC; // [RULE_10]
    wire en_a = USE_ENABLE_A ? (use_in ? en_a_ff : port_a_enable) : 1'b1; // [RULE_16]
    wire en_b = USE_ENABLE_B ? (use_in ? en_b_ff : port_b_enable) : 1'b1; // [RULE_16]
    wire [BYTES-1:0] we_raw = use_in ? we_a_ff : port_a_write_enable;
    wire [BYTES-1:0] we_a = USE_BYTE_WE ? we_raw : {BYTES{we_raw[0]}}; // [RULE_06]
    wire [ADDR_W-1:0] addr_a = use_in ? addr_a_ff : port_a_addr;
    wire [ADDR_W-1:0] addr_b = use_in ? addr_b_ff : port_b_addr;
    wire [WRITE_W-1:0] din_a = use_in ? din_a_ff : port_a_write_data;
    wire inj_s = use_in ? inj_s_ff : inject_single_bit_error;
    wire inj_d = use_in ? inj_d_ff : inject_double_bit_error;
    wire wr_go = en_a && (|we_a);
    wire rd_go = en_b;

    // Bank selects: only the accessed bank is enabled
    wire [BANK_AW-1:0] bank_a = BANK_AW'(addr_a >> LOW_AW);
    wire [BANK_AW-1:0] bank_b = BANK_AW'(addr_b >> LOW_AW);
    logic [BANKS-1:0] bank_wr_en, bank_rd_en;
    always_comb begin
        for (int k = 0; k < BANKS; k++) begin
            bank_wr_en[k] = wr_go && (!LOW_POWER || bank_a == BANK_AW'(k)); // [RULE_14]
            bank_rd_en[k] = rd_go && (!LOW_POWER || bank_b == BANK_AW'(k)); // [RULE_14]
        end
    end

    // Encoder and decoder
    logic [CODE_W-1:0] code_w, code_r, dec_in;
    logic [WRITE_W-1:0] dec_data;
    logic dec_s, dec_d;
    edpr_hamming #(
        .DATA_W(WRITE_W),
        .CHK_W(CHK_W)
    ) u_ham (
        .enc_data(din_a),
        .enc_code(code_w),
        .dec_code(dec_in),
        .dec_data(dec_data),
        .dec_single(dec_s),
        .dec_double(dec_d)
    );

    // Injection flips bit 1 for single, bits 1 and 2 for double
    wire [CODE_W-1:0] inj_mask = {{(CODE_W-3){1'b0}}, inj_d, inj_s | inj_d, 1'b0}; // [RULE_05]
    wire [CODE_W-1:0] wr_word = ECC_ON ? (code_w ^ inj_mask) : code_w;

    // Storage array; the whole code word is written whenever any byte enable is set (only bit 0 counts without USE_BYTE_WE)
    logic [CODE_W-1:0] mem [WRITE_DEPTH];
    wire [CODE_W-1:0] merged = wr_word;
    always_ff @(posedge core_clk) begin
        if (bank_wr_en[bank_a]) begin
            mem[addr_a] <= merged;
        end
    end

    // Plain byte-write path without ECC keeps data only
    logic [WRITE_W-1:0] raw_mem [WRITE_DEPTH];
    always_ff @(posedge core_clk) begin
        for (int k = 0; k < BYTES; k++) begin
            if (bank_wr_en[bank_a] && we_a[k]) begin
                for (int j = 0; j < BYTE_W; j++) begin
                    if (k * BYTE_W + j < WRITE_W)
                        raw_mem[addr_a][k*BYTE_W+j] <= din_a[k*BYTE_W+j]; // [RULE_13]
                end
            end
        end
    end

    // Read stage with collision handling
    wire collide = wr_go && rd_go && (addr_a == addr_b);
    logic [CODE_W-1:0] rd_code_ff;
    logic [WRITE_W-1:0] rd_raw_ff;
    logic rd_valid_ff, hold_ff;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_code_ff <= '0;
            rd_raw_ff <= '0;
            rd_valid_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            rd_valid_ff <= rd_go;
            hold_ff <= 1'b0;
            if (bank_rd_en[bank_b]) begin
                if (collide && MODE_B == edpr_pkg::EDPR_WRITE_FIRST) begin
                    rd_code_ff <= wr_word; // [RULE_18]
                    rd_raw_ff <= din_a;
                end else if (collide && MODE_B == edpr_pkg::EDPR_NO_CHANGE) begin
                    hold_ff <= 1'b1; // [RULE_15]
                end else begin
                    rd_code_ff <= mem[addr_b]; // [RULE_18]
                    rd_raw_ff <= raw_mem[addr_b];
                end
            end
        end
    end
    assign dec_in = rd_code_ff;

    // Decoded word and flags travel together
    wire [WRITE_W-1:0] rd_word = ECC_ON ? dec_data : rd_raw_ff; // [RULE_03]
    wire rd_s = ECC_ON && dec_s; // [RULE_19]
    wire rd_d = ECC_ON && dec_d; // [RULE_04]
    wire use_out = OUT_REG && ECC == edpr_pkg::EDPR_SOFT_ECC; // [RULE_10]

    logic [READ_W-1:0] out1_ff, out2_ff;
    logic v1_ff, s1_ff, d1_ff, v2_ff, s2_ff, d2_ff;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            out1_ff <= '0;
            v1_ff <= 1'b0;
            s1_ff <= 1'b0;
            d1_ff <= 1'b0;
        end else if (rd_valid_ff && !hold_ff) begin
            out1_ff <= READ_W'(rd_word);
            v1_ff <= 1'b1;
            s1_ff <= rd_s; // [RULE_19]
            d1_ff <= rd_d;
        end else begin
            v1_ff <= 1'b0;
        end
    end

    // Optional extra output stage
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            out2_ff <= '0;
            v2_ff <= 1'b0;
            s2_ff <= 1'b0;
            d2_ff <= 1'b0;
        end else begin
            out2_ff <= out1_ff;
            v2_ff <= v1_ff;
            s2_ff <= s1_ff;
            d2_ff <= d1_ff;
        end
    end

    always_comb begin
        port_b_read_data = use_out ? out2_ff : out1_ff;
        port_b_read_valid = use_out ? v2_ff : v1_ff;
        single_bit_error = use_out ? s2_ff : s1_ff;
        double_bit_error = use_out ? d2_ff : d1_ff;
    end

    // Checks on the read path and on the bank enables
    a_single_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!use_out && rd_valid_ff && !hold_ff && ECC_ON && dec_s) |=> single_bit_error) // [RULE_19]
        else $error("Single error flag missing");
    a_double_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!use_out && rd_valid_ff && !hold_ff && ECC_ON && dec_d) |=> double_bit_error) // [RULE_04]
        else $error("Double error flag missing");
    a_flags_excl: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(single_bit_error && double_bit_error)) // [RULE_03]
        else $error("Both error flags set");
    a_valid_timing: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!use_out && rd_go && !collide) |=> ##1 port_b_read_valid) // [RULE_16]
        else $error("Read data not valid in time");
    a_no_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!use_out && USE_ENABLE_B && !rd_go) |=> ##1 !port_b_read_valid) // [RULE_16]
        else $error("Read without enable");
    a_hold_output: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!use_out && collide && MODE_B == edpr_pkg::EDPR_NO_CHANGE)
        |=> ##1 $stable(port_b_read_data)) // [RULE_18]
        else $error("No-change output moved");
    a_write_first: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!use_out && !ECC_ON && collide && MODE_B == edpr_pkg::EDPR_WRITE_FIRST)
        |=> ##1 port_b_read_data == READ_W'($past(din_a, 2))) // [RULE_18]
        else $error("Write-first data wrong");
    a_low_power: assert property (@(posedge core_clk) disable iff (!rst_n)
        LOW_POWER |-> $countones(bank_wr_en) <= 1 && $countones(bank_rd_en) <= 1) // [RULE_14]
        else $error("Too many banks enabled");
    a_inject_seen: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ECC_ON && !use_out && wr_go && inj_d && !inj_s ##1 rd_go && addr_b == $past(addr_a)
        && !collide) |=> ##1 double_bit_error) // [RULE_05]
        else $error("Injected double error not reported");

    c_read: cover property (@(posedge core_clk) port_b_read_valid);
    c_single: cover property (@(posedge core_clk) single_bit_error);
    c_double: cover property (@(posedge core_clk) double_bit_error);
    c_collide: cover property (@(posedge core_clk) collide);
endmodule

// ==== testbench/edpr_user_model.sv ====
// User-side model driving the memory write and read ports
module edpr_user_model #(
    parameter int AW = 8,
    parameter int DW = 32,
    parameter int BW = 4
) (
    input wire logic core_clk,
    output logic port_a_enable,
    output logic [BW-1:0] port_a_write_enable,
    output logic [AW-1:0] port_a_addr,
    output logic [DW-1:0] port_a_write_data,
    output logic inject_single_bit_error,
    output logic inject_double_bit_error,
    output logic port_b_enable,
    output logic [AW-1:0] port_b_addr,
    input wire logic [DW-1:0] port_b_read_data,
    input wire logic port_b_read_valid,
    input wire logic single_bit_error,
    input wire logic double_bit_error
);
    timeunit 1ns;
    timeprecision 1ns;
    int cyc = 0;
    int issued[$];
    int lat[$];
    logic [DW+1:0] got[$];

    // Quiet ports from time zero; both ports share this one clock
    initial begin
        port_a_enable = 1'b0;
        port_a_write_enable = '1;
        port_a_addr = '0;
        port_a_write_data = '0;
        inject_single_bit_error = 1'b0;
        inject_double_bit_error = 1'b0;
        port_b_enable = 1'b0;
        port_b_addr = '1;
    end

    // One cycle of traffic; strobes stay high so only the enables gate
    task automatic op(input logic we, input logic re, input logic [AW-1:0] a,
                      input logic [DW-1:0] d, input logic [1:0] inj);
        port_a_enable <= we;
        port_a_addr <= we ? a : ~port_a_addr;
        port_a_write_data <= we ? d : ~port_a_write_data;
        inject_single_bit_error <= we & inj[0];
        inject_double_bit_error <= we & inj[1];
        port_b_enable <= re;
        port_b_addr <= re ? a : ~port_b_addr;
        @(posedge core_clk);
        if (re) begin
            issued.push_back(cyc);
        end
    endtask

    // Collect each returned word with its flags and latency
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (port_b_read_valid === 1'b1) begin
            got.push_back({port_b_read_data, single_bit_error, double_bit_error});
            lat.push_back(issued.size() ? cyc - issued.pop_front() : -1);
        end
    end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the ECC dual-port memory
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LAT = 2;
    logic core_clk;
    logic rst_n;
    logic port_a_enable;
    logic [3:0] port_a_write_enable;
    logic [7:0] port_a_addr;
    logic [31:0] port_a_write_data;
    logic inject_single_bit_error;
    logic inject_double_bit_error;
    logic port_b_enable;
    logic [7:0] port_b_addr;
    logic [31:0] port_b_read_data;
    logic port_b_read_valid;
    logic single_bit_error;
    logic double_bit_error;
    int fail_count = 0;
    int checks = 0;
    logic [7:0] edges[4] = '{8'h00, 8'h3f, 8'h40, 8'hff};

    edpr_ram i_edpr_ram (
        .core_clk(core_clk), .rst_n(rst_n), .port_a_enable(port_a_enable),
        .port_a_write_enable(port_a_write_enable), .port_a_addr(port_a_addr),
        .port_a_write_data(port_a_write_data),
        .inject_single_bit_error(inject_single_bit_error),
        .inject_double_bit_error(inject_double_bit_error),
        .port_b_enable(port_b_enable), .port_b_addr(port_b_addr),
        .port_b_read_data(port_b_read_data), .port_b_read_valid(port_b_read_valid),
        .single_bit_error(single_bit_error), .double_bit_error(double_bit_error)
    );

    edpr_user_model i_edpr_user_model (
        .core_clk(core_clk), .port_a_enable(port_a_enable),
        .port_a_write_enable(port_a_write_enable), .port_a_addr(port_a_addr),
        .port_a_write_data(port_a_write_data),
        .inject_single_bit_error(inject_single_bit_error),
        .inject_double_bit_error(inject_double_bit_error),
        .port_b_enable(port_b_enable), .port_b_addr(port_b_addr),
        .port_b_read_data(port_b_read_data), .port_b_read_valid(port_b_read_valid),
        .single_bit_error(single_bit_error), .double_bit_error(double_bit_error)
    );

    // 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Word pattern spreading the address over all bytes
    function automatic logic [31:0] pat(input logic [7:0] a);
        return {a, ~a, a, ~a} ^ 32'h8000_0001;
    endfunction

    task automatic check(input logic [33:0] g, input logic [33:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) i_edpr_user_model.op(1'b0, 1'b0, 8'h00, 32'h0, 2'b00);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] inj);
        i_edpr_user_model.op(1'b1, 1'b0, a, d, inj);
    endtask

    task automatic rd(input logic [7:0] a);
        i_edpr_user_model.op(1'b0, 1'b1, a, 32'h0, 2'b00);
    endtask

    // Next returned word: latency, data (unless undefined) and flags
    task automatic take(input logic [31:0] d, input logic sb, input logic db, input bit use_d);
        logic [33:0] g;
        int l;
        for (int i = 0; i < 8 && i_edpr_user_model.got.size() == 0; i++) begin
            @(posedge core_clk);
        end
        g = i_edpr_user_model.got.size() ? i_edpr_user_model.got.pop_front() : 34'h0;
        l = i_edpr_user_model.lat.size() ? i_edpr_user_model.lat.pop_front() : -9;
        check(34'(l), 34'(LAT));
        check(use_d ? g : {d, g[1:0]}, {d, sb, db});
    endtask

    task automatic wrap_up();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Cut a hang short; the tests need under a hundred cycles
    initial begin
        repeat (3000) @(posedge core_clk);
        fail_count++;
        wrap_up();
    end

    initial begin
        rst_n = 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        check({port_b_read_valid, single_bit_error, double_bit_error}, 34'h0);
        @(posedge core_clk);
        rst_n <= 1'b1;
        idle(2);
        // Bank edges written and read back to back; idles carry strobes
        foreach (edges[i]) wr(edges[i], pat(edges[i]), 2'b00);
        idle(1);
        foreach (edges[i]) rd(edges[i]);
        idle(3);
        foreach (edges[i]) take(pat(edges[i]), 1'b0, 1'b0, 1'b1);
        $display("test bank edges done");
        // Injected errors: single corrected, double only flagged
        wr(8'h10, 32'hdead_beef, 2'b01);
        wr(8'h11, 32'h1234_5678, 2'b10);
        wr(8'h12, 32'hffff_ffff, 2'b11);
        rd(8'h10);
        rd(8'h11);
        rd(8'h12);
        idle(3);
        take(32'hdead_beef, 1'b1, 1'b0, 1'b1);
        take(32'h1234_5678, 1'b0, 1'b1, 1'b0);
        take(32'hffff_ffff, 1'b0, 1'b1, 1'b0);
        $display("test injection done");
        // Flags follow each word through back-to-back reads
        wr(8'h11, 32'h0000_0000, 2'b00);
        rd(8'h10);
        rd(8'h11);
        rd(8'h10);
        idle(3);
        take(32'hdead_beef, 1'b1, 1'b0, 1'b1);
        take(32'h0000_0000, 1'b0, 1'b0, 1'b1);
        take(32'hdead_beef, 1'b1, 1'b0, 1'b1);
        // Double injection read back on the very next cycle
        wr(8'h13, 32'h0f0f_3c3c, 2'b10);
        rd(8'h13);
        idle(3);
        take(32'h0f0f_3c3c, 1'b0, 1'b1, 1'b0);
        $display("test flag alignment done");
        // Same-cycle write and read: old word first, new word after
        wr(8'h20, 32'ha5a5_0001, 2'b00);
        i_edpr_user_model.op(1'b1, 1'b1, 8'h20, 32'h5a5a_0002, 2'b00);
        rd(8'h20);
        idle(3);
        take(32'ha5a5_0001, 1'b0, 1'b0, 1'b1);
        take(32'h5a5a_0002, 1'b0, 1'b0, 1'b1);
        $display("test collision done");
        // No unrequested words may have come back
        idle(4);
        check(34'(i_edpr_user_model.got.size()), 34'h0);
        wrap_up();
    end
endmodule
